// ===== src/rcp_pkg.sv
// Constants for the reset, bus clock and interrupt pin block
package rcp_pkg;
  localparam int unsigned RCP_CLK_HZ = 25_000_000;
  localparam int unsigned RCP_DIV_RATIO = 4;
  localparam logic [1:0] RCP_PHASE_RISE = 2'h1;
  localparam logic [1:0] RCP_PHASE_FALL = 2'h3;
  localparam int unsigned RCP_CLASSIFY_ECYC = 2;
  localparam int unsigned RCP_RESET_HOLD_ECYC = 4;
  localparam logic RCP_IRQ_EDGE_RST = 1'b0;
  localparam logic RCP_XMASK_RST = 1'b1;
  localparam logic RCP_BUSCLK_EN_RST = 1'b1;

  typedef enum logic [1:0] {
    RCP_ST_RUN = 2'b00,
    RCP_ST_DRIVE = 2'b01,
    RCP_ST_SENSE = 2'b10
  } rcp_state_t;
endpackage

// ===== src/rcp_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rcp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ===== src/rcp_top.sv
// Reset pin, bus clock output and interrupt pin logic
// Summary of operation
// - Low reset pin initialises all logic
// - Watchdog or clock fault pulls reset low
// - Pin high within two cycles means internal
// - Bus clock is oscillator divided by four
// - Low phase processes, high phase accesses
// - Stop mode halts all clocks
// - Bus clock pin may be disabled single-chip
// - Maskable interrupt accepted asynchronously
// - Option bit selects falling edge or level
// - Maskable input level-sensitive after reset
// - Reset sets nonmaskable mask; clear once only
// - Nonmaskable input is low-level sensitive
`timescale 1ns/1ps
module rcp_top
  import rcp_pkg::*;
#(
  parameter bit BUSCLK_ALWAYS_ON = 1'b0,
  parameter int unsigned CLASSIFY_ECYC = RCP_CLASSIFY_ECYC,
  parameter int unsigned HOLD_ECYC = RCP_RESET_HOLD_ECYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic watchdog_monitor_fail,
  input wire logic clock_monitor_fail,
  input wire logic stop_mode,
  input wire logic single_chip_mode,
  input wire logic busclk_disable,
  output logic bus_clk_out,
  output logic access_phase,
  output logic process_phase,
  output logic bus_tick,
  input wire logic irq_n_in,
  input wire logic irq_edge_wr,
  input wire logic irq_edge_val,
  input wire logic irq_ack,
  output logic irq_edge_mode,
  output logic irq_pending,
  input wire logic nonmaskable_irq_in,
  input wire logic xmask_clear,
  output logic xmask,
  output logic nonmaskable_pending,
  output logic sys_reset,
  output logic reset_internal,
  output logic reset_external,
  output logic reset_done
);
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CLASSIFY_CNT = CNT_W'(CLASSIFY_ECYC);
  localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_ECYC);

  logic rst_pin_s;
  logic irq_s;
  logic nonmaskable_irq_in_s;
  logic irq_s_prev_q;
  logic [1:0] div_q;
  rcp_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic any_reset;
  logic irq_fall;
  logic ext_rst_q;

  // Last oscillator cycle of a bus cycle
  function automatic logic is_fall(logic [1:0] phase);
    return phase == RCP_PHASE_FALL;
  endfunction

  rcp_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_rst (
    .clk(clk),
    .rst(rst),
    .d(reset_pin_in),
    .q(rst_pin_s)
  );

  rcp_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync_irq (
    .clk(clk),
    .rst(rst),
    .d({irq_n_in, nonmaskable_irq_in}),
    .q({irq_s, nonmaskable_irq_in_s})
  );

  // Bus clock divider, frozen while stopped
  always_ff @(posedge clk) begin
    if (rst || any_reset) begin
      div_q <= 2'h0;
    end else if (!stop_mode) begin
      div_q <= div_q + 2'h1;
    end
  end

  // Output held low while stopped or disabled; low level is the quiet state
  always_ff @(posedge clk) begin
    if (rst || stop_mode) begin
      bus_clk_out <= 1'b0;
    end else if (!BUSCLK_ALWAYS_ON && single_chip_mode && busclk_disable) begin
      bus_clk_out <= 1'b0;
    end else begin
      bus_clk_out <= div_q[1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      access_phase <= 1'b0;
    end else begin
      access_phase <= !stop_mode && div_q[1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      process_phase <= 1'b0;
    end else begin
      process_phase <= !stop_mode && !div_q[1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_tick <= 1'b0;
    end else begin
      bus_tick <= !stop_mode && is_fall(div_q);
    end
  end

  // External reset seen on the pin while not driving it ourselves
  assign any_reset = (!rst_pin_s && state_q == RCP_ST_RUN) || rst;

  // Reset sequencer: drive, release, sense
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RCP_ST_SENSE;
      cnt_q <= '0;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b0;
      sys_reset <= 1'b1;
      reset_internal <= 1'b0;
      reset_external <= 1'b0;
      reset_done <= 1'b0;
      ext_rst_q <= 1'b1;
    end else begin
      reset_done <= 1'b0;
      case (state_q)
        RCP_ST_RUN: begin
          if (watchdog_monitor_fail || clock_monitor_fail) begin
            state_q <= RCP_ST_DRIVE;
            reset_pin_oe <= 1'b1;
            sys_reset <= 1'b1;
            cnt_q <= '0;
            ext_rst_q <= 1'b0;
          end else if (!rst_pin_s) begin
            state_q <= RCP_ST_SENSE;
            sys_reset <= 1'b1;
            cnt_q <= '0;
            ext_rst_q <= 1'b1;
          end
        end
        RCP_ST_DRIVE: begin
          if (is_fall(div_q)) begin
            if (cnt_q == HOLD_CNT - 8'h01) begin
              state_q <= RCP_ST_SENSE;
              reset_pin_oe <= 1'b0;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 8'h01;
            end
          end
        end
        RCP_ST_SENSE: begin
          if (is_fall(div_q)) begin
            if (cnt_q == CLASSIFY_CNT - 8'h01) begin
              // Pin still low after window: external source holds it
              if (rst_pin_s) begin
                state_q <= RCP_ST_RUN;
                sys_reset <= 1'b0;
                reset_done <= 1'b1;
                reset_internal <= !ext_rst_q;
                reset_external <= ext_rst_q;
              end else begin
                ext_rst_q <= 1'b1;
                cnt_q <= CLASSIFY_CNT - 8'h01;
              end
            end else begin
              cnt_q <= cnt_q + 8'h01;
            end
          end
        end
        default: begin
          state_q <= RCP_ST_SENSE;
        end
      endcase
    end
  end

  // Maskable interrupt mode and latch
  always_ff @(posedge clk) begin
    if (rst || sys_reset) begin
      irq_edge_mode <= RCP_IRQ_EDGE_RST;
    end else if (irq_edge_wr) begin
      irq_edge_mode <= irq_edge_val;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_s_prev_q <= 1'b1;
    end else begin
      irq_s_prev_q <= irq_s;
    end
  end

  assign irq_fall = irq_s_prev_q && !irq_s;

  always_ff @(posedge clk) begin
    if (rst || sys_reset) begin
      irq_pending <= 1'b0;
    end else if (irq_edge_mode) begin
      // New edge wins over acknowledge
      if (irq_fall) begin
        irq_pending <= 1'b1;
      end else if (irq_ack) begin
        irq_pending <= 1'b0;
      end
    end else begin
      irq_pending <= !irq_s;
    end
  end

  // Mask can only be cleared, never set again outside reset
  always_ff @(posedge clk) begin
    if (rst || sys_reset) begin
      xmask <= RCP_XMASK_RST;
    end else if (xmask_clear) begin
      xmask <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || sys_reset) begin
      nonmaskable_pending <= 1'b0;
    end else begin
      nonmaskable_pending <= !xmask && !nonmaskable_irq_in_s;
    end
  end
endmodule

// ===== bench/rcp_chk_checker.sv
// Checker for the reset, bus clock and interrupt pin block
`timescale 1ns/1ps
module rcp_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic watchdog_monitor_fail,
  input wire logic clock_monitor_fail,
  input wire logic sys_reset,
  input wire logic stop_mode,
  input wire logic bus_clk_out,
  input wire logic bus_tick,
  input wire logic irq_n_in,
  input wire logic irq_edge_mode,
  input wire logic irq_pending,
  input wire logic xmask,
  input wire logic nonmaskable_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_fault_pulls_pin: assert property ((watchdog_monitor_fail || clock_monitor_fail) && !sys_reset && reset_pin_in
    |=> reset_pin_oe) else $error("fault ignored");
  a_pin_drives_low: assert property (reset_pin_oe |-> !reset_pin_out && sys_reset)
    else $error("pin not low");
  a_oe_holds: assert property ($rose(reset_pin_oe) |=> reset_pin_oe[*8])
    else $error("pin released early");
  a_tick_gap: assert property (bus_tick |=> !bus_tick[*3]) else $error("tick too soon");
  // An external reset on the pin restarts the divider, so only clean running windows are checked
  a_tick_period: assert property ((bus_tick && !stop_mode) ##1 (!stop_mode && !sys_reset)[*4] |-> bus_tick)
    else $error("tick missing");
  a_stop_halts: assert property (stop_mode[*2] |-> !bus_clk_out) else $error("clock runs in stop");
  a_level_irq: assert property ((!irq_n_in && !irq_edge_mode && !sys_reset)[*4] |-> irq_pending)
    else $error("level request lost");
  a_xmask_masks: assert property (xmask |-> !nonmaskable_pending) else $error("masked request seen");
endmodule
bind rcp_top rcp_chk chk_u (.*);

// ===== bench/rcp_far.sv
// Far side: reset circuit and open-drain interrupt sources
`timescale 1ns/1ps
module rcp_far (
  input wire logic clk,
  input wire logic reset_pin_oe,
  input wire logic ext_rst,
  input wire logic [1:0] irq_req,
  input wire logic src_rel,
  input wire logic nonmaskable_irq_in_req,
  output logic reset_pin_in,
  output logic irq_n_in,
  output logic nonmaskable_irq_in
);
  logic [1:0] src_q = 2'h0;
  always_ff @(posedge clk) begin
    src_q <= src_rel ? 2'h0 : src_q | irq_req;
  end
  // Pull-ups; every party only pulls low
  assign reset_pin_in = !(reset_pin_oe || ext_rst);
  assign irq_n_in = !(|src_q);
  assign nonmaskable_irq_in = !nonmaskable_irq_in_req;
endmodule

// ===== bench/tb.sv
// Bench for the reset, bus clock and interrupt pin block
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, watchdog_monitor_fail = 0, clock_monitor_fail = 0, stop_mode = 0, prev;
  logic single_chip_mode = 0, busclk_disable = 0, irq_edge_wr = 0, irq_edge_val = 0, irq_ack = 0;
  logic xmask_clear = 0, ext_rst = 0, src_rel = 0, nonmaskable_irq_in_req = 0, reset_pin_in, reset_pin_out;
  logic reset_pin_oe, bus_clk_out, access_phase, process_phase, bus_tick, irq_n_in, irq_edge_mode;
  logic irq_pending, nonmaskable_irq_in, xmask, nonmaskable_pending, sys_reset, reset_internal;
  logic reset_external, reset_done;
  logic [1:0] irq_req = 2'h0;
  logic [2:0] modes [3] = '{3'h0, 3'h4, 3'h3};
  logic [1:0] exp_q[$];
  int n_errors = 0, n_tests = 0, rises;
  rcp_top dut_u (.*);
  rcp_far far_u (.*);
  task automatic chk(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wait_done;
    for (int k = 0; k < 300 && reset_done !== 1'h1; k++) cyc(1);
    cyc(1);
  endtask
  task automatic tally_and_finish;
    chk("notes left", 0, exp_q.size() != 0);
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    if (reset_done === 1'h1 && exp_q.size() > 0) begin
      n_tests++;
      if ({reset_internal, reset_external} !== exp_q[0]) begin
        n_errors++;
        $display("CHECK FAILED class expected %0h seen %0h", exp_q[0], {reset_internal, reset_external});
      end
      void'(exp_q.pop_front());
    end
  end
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #2_000_000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(74));
    cyc(20);
    rst = 0;
    wait_done;
    chk("xmask", 1, xmask);
    chk("edge mode", 0, irq_edge_mode);
    nonmaskable_irq_in_req = 1;
    cyc(5);
    chk("nonmaskable_irq_in masked", 0, nonmaskable_pending);
    xmask_clear = 1;
    cyc(1);
    xmask_clear = 0;
    cyc(4);
    chk("nonmaskable_irq_in level", 1, nonmaskable_pending);
    nonmaskable_irq_in_req = 0;
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(i < 2 ? 2'h2 : 2'h1);
      {watchdog_monitor_fail, clock_monitor_fail, ext_rst} = 3'h4 >> i;
      cyc(i < 2 ? 1 : 16 + $urandom % 16);
      {watchdog_monitor_fail, clock_monitor_fail, ext_rst} = 3'h0;
      wait_done;
      chk("xmask set", 1, xmask);
    end
    $display("reset tests done");
    for (int m = 0; m < 3; m++) begin
      {stop_mode, single_chip_mode, busclk_disable} = modes[m];
      rises = 0;
      cyc(2);
      repeat (80) begin
        prev = bus_clk_out;
        cyc(1);
        rises += int'(bus_clk_out && !prev);
        if (m != 2) chk("phase", 1, {access_phase, process_phase} == (m ? 2'h0 : {bus_clk_out, !bus_clk_out}));
      end
      chk("bus clock rises", 1, rises == (m ? 0 : 20));
    end
    {stop_mode, single_chip_mode, busclk_disable} = 3'h0;
    $display("bus clock tests done");
    for (int e = 0; e < 2; e++) begin
      {irq_edge_wr, irq_edge_val} = {1'h1, e[0]};
      cyc(1);
      irq_edge_wr = 0;
      chk("edge mode", e[0], irq_edge_mode);
      irq_req[$urandom % 2] = 1'h1;
      cyc(1);
      irq_req = 2'h0;
      cyc(5);
      chk("irq raised", 1, irq_pending);
      src_rel = 1;
      cyc(1);
      src_rel = 0;
      cyc(5);
      chk("irq after release", e[0], irq_pending);
      irq_ack = 1;
      cyc(1);
      irq_ack = 0;
      cyc(1);
      chk("irq after ack", 0, irq_pending);
    end
    $display("irq tests done");
    tally_and_finish();
  end
endmodule
